/* core/crs_pkg.sv */
// Operation
// [R1] No card is fed until a feed instruction; one card per instruction.
// [R2] Twelve row strobes 24 degrees apart, then a 96 degree gap, per card.
// [R3] Each row strobe gives one probe pulse to both read stations together.
// [R4] With no card present in the stations, no probe pulse is generated.
// [R5] Sensing roll drive is inactive except while a row is probed.
// [R6] Rows build a card image in the buffer, kept until transfer instruction.
// [R7] Unprimed part: four low bits from rows 5, 3, 1, 0; ten per word.
// [R8] Primed part: rows 9 and 7 plus two unused bits, in another word.
// [R9] Ten blocks per card; blocks 4 and 9 hold five characters, others ten.
// [R10] Each word is known by station, block and primed or unprimed half.
// [R11] Buffer has 200 words; 000-099 reader, 100-199 read-punch unit.
// [R12] Four tracks, two headbars of four heads, headbars 180 degrees apart.
// [R13] A complete image moves to main storage within one drum revolution.
// [R14] Reader-to-buffer writes never use the main-storage write circuits.
// [R15] A fed card passes both stations unaided, then to the chosen stacker.
// [R16] Headbar 1 writes either half; headbar 2 writes only the reader half.
// [R17] Row counter advances per strobe and restarts when the gap is seen.
package crs_pkg;
    localparam int ROWS        = 12;
    localparam int COLS        = 90;
    localparam int STATIONS    = 2;
    localparam int BLOCKS      = 10;
    localparam int DIGITS      = 10;
    localparam int CHAR_BITS   = 4;
    localparam int WORD_W      = DIGITS * CHAR_BITS;
    localparam int IMG_WORDS   = STATIONS * BLOCKS * 2;
    localparam int BUF_WORDS   = 200;
    localparam int READER_TOP  = 100;
    localparam int HEADS       = 4;
    localparam int BLK_STRIDE  = 10;
    localparam int PRIMED_OFS  = 5;
    localparam int BUF_HI_OFS  = 1;
    localparam int MS_LO_OFS   = 1;
    localparam int MS_HI_OFS   = 102;
    localparam int HALF_COLS   = 45;
    localparam int SHORT_COLS  = 5;
    // Card rows feeding each character bit
    localparam int ROW_U0      = 0;
    localparam int ROW_U1      = 1;
    localparam int ROW_U2      = 3;
    localparam int ROW_U3      = 5;
    localparam int ROW_P0      = 7;
    localparam int ROW_P1      = 9;
    localparam int LAST_ROW    = ROWS - 1;
    localparam int GAP_RATIO   = 2;
    localparam int IVL_W       = 16;
    // Timing
    localparam int SYS_CLK_MHZ = 200;
    localparam int LINK_CLK_NS = 32;
    localparam int PROBE_NS    = 256;
    localparam int PROBE_CYC   = (PROBE_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam int PICK_NS     = 640;
    localparam int PICK_CYC    = (PICK_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam int DRUM_REV_US = 17;
    localparam int DRUM_REV_CYC = DRUM_REV_US * SYS_CLK_MHZ;
    localparam int FIFO_DEPTH  = 4;

    typedef enum {CRS_IDLE, CRS_STORE, CRS_XFER} crs_state_e;
endpackage : crs_pkg

/* core/crs_reader_sync.sv */
`timescale 1ns/10ps

module crs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // Fill side
    input  wire logic         wr_clk_i,
    input  wire logic         wr_rst_i,
    input  wire logic         wr_valid_i,
    output logic              wr_ready_o,
    input  wire logic [W-1:0] wr_data_i,
    // Drain side
    input  wire logic         rd_clk_i,
    input  wire logic         rd_rst_i,
    output logic              rd_valid_o,
    input  wire logic         rd_ready_i,
    output logic [W-1:0]      rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 4 || (1 << AW) != DEPTH || W < 1)
            $error("crs_fifo: DEPTH must be a power of two of 4 or more");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [AW:0]  rg_meta_reg, rg_sync_reg, wg_meta_reg, wg_sync_reg;
    logic [AW:0]  wbin_next, rbin_next;

    assign wbin_next  = wbin_reg + 1'b1;
    assign rbin_next  = rbin_reg + 1'b1;
    // Full when write gray is read gray with top two bits inverted
    assign wr_ready_o = wgray_reg !=
        {~rg_sync_reg[AW:AW-1], rg_sync_reg[AW-2:0]};
    assign rd_valid_o = rgray_reg != wg_sync_reg;
    assign rd_data_o  = mem[rbin_reg[AW-1:0]];

    always_ff @(posedge wr_clk_i) begin
        if (wr_valid_i && wr_ready_o)
            mem[wbin_reg[AW-1:0]] <= wr_data_i;
    end

    always_ff @(posedge wr_clk_i) begin
        if (wr_rst_i) begin
            wbin_reg  <= '0;
            wgray_reg <= '0;
        end else if (wr_valid_i && wr_ready_o) begin
            wbin_reg  <= wbin_next;
            wgray_reg <= wbin_next ^ (wbin_next >> 1);
        end
    end

    always_ff @(posedge wr_clk_i) begin
        if (wr_rst_i) begin
            rg_meta_reg <= '0;
            rg_sync_reg <= '0;
        end else begin
            rg_meta_reg <= rgray_reg;
            rg_sync_reg <= rg_meta_reg;
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst_i) begin
            rbin_reg  <= '0;
            rgray_reg <= '0;
        end else if (rd_valid_o && rd_ready_i) begin
            rbin_reg  <= rbin_next;
            rgray_reg <= rbin_next ^ (rbin_next >> 1);
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst_i) begin
            wg_meta_reg <= '0;
            wg_sync_reg <= '0;
        end else begin
            wg_meta_reg <= wgray_reg;
            wg_sync_reg <= wg_meta_reg;
        end
    end
endmodule : crs_fifo

module crs_reader_sync
    import crs_pkg::*;
#(
    parameter int FIFO_W = 1 + 4 + STATIONS * COLS
) (
    // System side
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Processor instructions
    input  wire logic              feed_cmd_i,
    input  wire logic [1:0]        stacker_i,
    input  wire logic              xfer_cmd_i,
    output logic                   image_ready_o,
    output logic                   xfer_busy_o,
    output logic                   timing_err_o,
    // Main-storage write port
    output logic                   ms_wr_o,
    output logic [7:0]             ms_addr_o,
    output logic [WORD_W-1:0]      ms_data_o,
    // Reader link side
    input  wire logic              link_clk_i,
    input  wire logic              slot_i,
    input  wire logic              card_present_i,
    input  wire logic [COLS-1:0]   brush1_i,
    input  wire logic [COLS-1:0]   brush2_i,
    output logic                   probe_o,
    output logic                   pick_o,
    output logic [1:0]             stacker_o
);
    initial begin
        if (FIFO_W != 1 + 4 + STATIONS * COLS)
            $error("crs_reader_sync: FIFO_W must match the row word");
        if (IMG_WORDS >= DRUM_REV_CYC)
            $error("crs_reader_sync: transfer exceeds one revolution");
    end

    function automatic int col_block(input int c);
        if (c < HALF_COLS - SHORT_COLS)
            return c / DIGITS;
        else if (c < HALF_COLS)
            return BLOCKS / 2 - 1;
        else if (c < COLS - SHORT_COLS)
            return BLOCKS / 2 + (c - HALF_COLS) / DIGITS;
        else
            return BLOCKS - 1;
    endfunction : col_block

    function automatic int col_digit(input int c);
        if (c < HALF_COLS - SHORT_COLS)
            return c % DIGITS;
        else if (c < HALF_COLS)
            return c - (HALF_COLS - SHORT_COLS);
        else if (c < COLS - SHORT_COLS)
            return (c - HALF_COLS) % DIGITS;
        else
            return c - (COLS - SHORT_COLS);
    endfunction : col_digit

    // Word slot pairs station 1 and 2 of a block-pair group
    function automatic int grp(input int s, input int b);
        return (b % (BLOCKS / 2)) * 2 + s;
    endfunction : grp

    function automatic logic [7:0] buf_addr(input int s, input int b,
                                            input int pr);
        int a;
        a = grp(s, b) * BLK_STRIDE + pr * PRIMED_OFS;
        if (b >= BLOCKS / 2)
            a = a + BUF_HI_OFS;
        return a[7:0];
    endfunction : buf_addr

    function automatic logic [7:0] ms_addr(input int s, input int b,
                                           input int pr);
        int a;
        a = grp(s, b) * BLK_STRIDE + pr * PRIMED_OFS;
        a = a + ((b >= BLOCKS / 2) ? MS_HI_OFS : MS_LO_OFS);
        return a[7:0];
    endfunction : ms_addr

    // Link-domain reset and input synchronisers
    logic              lrst_meta_reg, lrst_reg;
    logic              slot_meta_reg, slot_s_reg, slot_d_reg;
    logic              card_meta_reg, card_s_reg;
    logic [COLS-1:0]   b1_meta_reg, b1_s_reg, b2_meta_reg, b2_s_reg;

    always_ff @(posedge link_clk_i) begin
        lrst_meta_reg <= rst_i;
        lrst_reg      <= lrst_meta_reg;
    end

    always_ff @(posedge link_clk_i) begin
        slot_meta_reg <= slot_i;
        slot_s_reg    <= slot_meta_reg;
        slot_d_reg    <= slot_s_reg;
        card_meta_reg <= card_present_i;
        card_s_reg    <= card_meta_reg;
        b1_meta_reg   <= brush1_i;
        b1_s_reg      <= b1_meta_reg;
        b2_meta_reg   <= brush2_i;
        b2_s_reg      <= b2_meta_reg;
    end

    // Row tracking from the timing disc
    logic              slot_rise;
    logic [IVL_W-1:0]  ivl_cnt_reg, prev_ivl_reg;
    logic [3:0]        row_reg, strobe_cnt_reg, row_now;
    logic              gap_seen, lerr_reg;

    assign slot_rise = slot_s_reg && !slot_d_reg;
    // The gap spans four slot pitches; twice the last pitch separates it
    assign gap_seen  = (prev_ivl_reg != '0) &&
        ({1'b0, ivl_cnt_reg} > ({1'b0, prev_ivl_reg} << 1));  // R2
    assign row_now   = gap_seen ? 4'h0 : row_reg + 4'h1;      // R17

    always_ff @(posedge link_clk_i) begin
        // Saturated start keeps a partial first pitch out of the gap test
        if (lrst_reg) begin
            ivl_cnt_reg  <= '1;
            prev_ivl_reg <= '0;
        end else if (slot_rise) begin
            ivl_cnt_reg  <= '0;
            prev_ivl_reg <= gap_seen ? prev_ivl_reg : ivl_cnt_reg;
        end else if (ivl_cnt_reg != '1) begin
            ivl_cnt_reg  <= ivl_cnt_reg + 1'b1;
        end
    end

    // Row index restarts at the gap; saturates if the gap never comes
    always_ff @(posedge link_clk_i) begin
        if (lrst_reg)
            row_reg <= 4'he;
        else if (slot_rise && (gap_seen || row_reg != 4'he))
            row_reg <= row_now;                               // R17
    end

    // All ones marks no gap since reset, so the first partial card is spared
    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            strobe_cnt_reg <= 4'hf;
            lerr_reg       <= 1'b0;
        end else if (slot_rise && gap_seen) begin
            strobe_cnt_reg <= 4'h1;
            if (strobe_cnt_reg != 4'(ROWS) && strobe_cnt_reg != 4'hf)
                lerr_reg <= 1'b1;                             // R2
        end else if (slot_rise && strobe_cnt_reg < 4'he) begin
            strobe_cnt_reg <= strobe_cnt_reg + 4'h1;
        end
    end

    // Probe generation and row capture
    logic [4:0]          probe_cnt_reg;
    logic [3:0]          probe_row_reg;
    logic                probe_reg, pend_reg, fifo_wr_ready;
    logic [FIFO_W-1:0]   pend_data_reg;

    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            probe_cnt_reg <= '0;
            probe_row_reg <= '0;
            probe_reg     <= 1'b0;
        end else if (probe_cnt_reg != '0) begin
            probe_cnt_reg <= probe_cnt_reg - 5'h1;
            probe_reg     <= probe_cnt_reg != 5'h1;           // R5
        end else if (slot_rise && card_s_reg && !pend_reg &&
                     row_now < 4'(ROWS)) begin                 // R4
            probe_cnt_reg <= 5'(PROBE_CYC);
            probe_row_reg <= row_now;
            probe_reg     <= 1'b1;                            // R3
        end else begin
            probe_reg     <= 1'b0;                            // R5
        end
    end

    // A full FIFO holds the pending row, which withholds the next probe
    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            pend_reg      <= 1'b0;
            pend_data_reg <= '0;
        end else if (probe_cnt_reg == 5'h1) begin
            pend_reg      <= 1'b1;
            pend_data_reg <= {probe_row_reg == 4'(LAST_ROW),
                              probe_row_reg, b2_s_reg, b1_s_reg};
        end else if (pend_reg && fifo_wr_ready) begin
            pend_reg      <= 1'b0;
        end
    end

    assign probe_o = probe_reg;

    // Feed request crossing: toggle plus held stacker choice
    logic       feed_tgl_reg, ft_meta_reg, ft_s_reg, ft_d_reg;
    logic [1:0] stacker_hold_reg, stacker_reg;
    logic [4:0] pick_cnt_reg;
    logic       pick_reg;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            feed_tgl_reg     <= 1'b0;
            stacker_hold_reg <= '0;
        end else if (feed_cmd_i) begin
            feed_tgl_reg     <= !feed_tgl_reg;                 // R1
            stacker_hold_reg <= stacker_i;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            ft_meta_reg <= 1'b0;
            ft_s_reg    <= 1'b0;
            ft_d_reg    <= 1'b0;
        end else begin
            ft_meta_reg <= feed_tgl_reg;
            ft_s_reg    <= ft_meta_reg;
            ft_d_reg    <= ft_s_reg;
        end
    end

    // Pickerknife fires once per instruction; the card then runs unaided
    always_ff @(posedge link_clk_i) begin
        if (lrst_reg) begin
            pick_cnt_reg <= '0;
            pick_reg     <= 1'b0;
            stacker_reg  <= '0;
        end else if (ft_s_reg != ft_d_reg) begin
            pick_cnt_reg <= 5'(PICK_CYC - 1);
            pick_reg     <= 1'b1;                              // R1
            stacker_reg  <= stacker_hold_reg;                  // R15
        end else if (pick_cnt_reg != '0) begin
            pick_cnt_reg <= pick_cnt_reg - 5'h1;
        end else begin
            pick_reg     <= 1'b0;
        end
    end

    assign pick_o    = pick_reg;
    assign stacker_o = stacker_reg;

    // Row FIFO across the domains
    logic              rd_valid, rd_ready;
    logic [FIFO_W-1:0] rd_data;

    crs_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .wr_clk_i   (link_clk_i),
        .wr_rst_i   (lrst_reg),
        .wr_valid_i (pend_reg),
        .wr_ready_o (fifo_wr_ready),
        .wr_data_i  (pend_data_reg),
        .rd_clk_i   (sys_clk_i),
        .rd_rst_i   (rst_i),
        .rd_valid_o (rd_valid),
        .rd_ready_i (rd_ready),
        .rd_data_o  (rd_data)
    );

    // System-domain image assembly and buffer band
    crs_state_e        state_reg;
    logic [5:0]        idx_reg;
    logic              last_pop, img_clr, head2_reg;
    logic              image_ready_reg, xfer_req_reg;
    logic              terr_meta_reg, terr_reg;
    logic [WORD_W-1:0] img_reg [STATIONS][2][BLOCKS];
    logic [WORD_W-1:0] buf_mem [BUF_WORDS];
    logic [3:0]        pop_row;
    int                cur_s, cur_b, cur_p;

    assign rd_ready = state_reg == CRS_IDLE;
    assign pop_row  = rd_data[FIFO_W-2 -: 4];
    assign last_pop = rd_valid && rd_ready && rd_data[FIFO_W-1];
    assign img_clr  = state_reg == CRS_STORE && idx_reg == 6'(IMG_WORDS - 1);
    assign cur_s    = int'(idx_reg) / (BLOCKS * 2);
    assign cur_b    = (int'(idx_reg) % (BLOCKS * 2)) / 2;
    assign cur_p    = int'(idx_reg) % 2;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= CRS_IDLE;
            idx_reg   <= '0;
        end else begin
            unique case (state_reg)
                CRS_IDLE: begin
                    idx_reg <= '0;
                    if (last_pop)
                        state_reg <= CRS_STORE;
                    else if (xfer_req_reg && image_ready_reg)
                        state_reg <= CRS_XFER;                 // R6
                end
                CRS_STORE, CRS_XFER: begin
                    idx_reg <= idx_reg + 6'h1;
                    if (idx_reg == 6'(IMG_WORDS - 1))
                        state_reg <= CRS_IDLE;                 // R13
                end
            endcase
        end
    end

    // Unprimed rows fill bits 3..0, primed rows bits 1..0 of a character
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || img_clr) begin
            for (int s = 0; s < STATIONS; s++)
                for (int p = 0; p < 2; p++)
                    for (int b = 0; b < BLOCKS; b++)
                        img_reg[s][p][b] <= '0;
        end else if (rd_valid && rd_ready) begin
            for (int s = 0; s < STATIONS; s++) begin
                for (int c = 0; c < COLS; c++) begin
                    unique case (int'(pop_row))
                        ROW_U0: img_reg[s][0][col_block(c)]
                            [col_digit(c) * CHAR_BITS + 0] <=
                            rd_data[s * COLS + c];            // R7
                        ROW_U1: img_reg[s][0][col_block(c)]
                            [col_digit(c) * CHAR_BITS + 1] <=
                            rd_data[s * COLS + c];            // R7
                        ROW_U2: img_reg[s][0][col_block(c)]
                            [col_digit(c) * CHAR_BITS + 2] <=
                            rd_data[s * COLS + c];            // R7
                        ROW_U3: img_reg[s][0][col_block(c)]
                            [col_digit(c) * CHAR_BITS + 3] <=
                            rd_data[s * COLS + c];            // R7
                        ROW_P0: img_reg[s][1][col_block(c)]
                            [col_digit(c) * CHAR_BITS + 0] <=
                            rd_data[s * COLS + c];            // R8
                        ROW_P1: img_reg[s][1][col_block(c)]
                            [col_digit(c) * CHAR_BITS + 1] <=
                            rd_data[s * COLS + c];            // R8
                        default: ;
                    endcase
                end
            end
        end
    end

    // Buffer writes stay off the main-storage port entirely
    always_ff @(posedge sys_clk_i) begin
        if (state_reg == CRS_STORE &&
            (!head2_reg || buf_addr(cur_s, cur_b, cur_p) < 8'(READER_TOP)))
            buf_mem[buf_addr(cur_s, cur_b, cur_p)] <=
                img_reg[cur_s][cur_p][cur_b];   // R6 R9 R10 R11 R14 R16
    end

    // Writing headbar alternates by card, as the two start points do
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            head2_reg <= 1'b0;
        else if (img_clr)
            head2_reg <= !head2_reg;                           // R12
    end

    // A new image arriving as a transfer ends still marks ready
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            image_ready_reg <= 1'b0;
            xfer_req_reg    <= 1'b0;
        end else begin
            if (img_clr)
                image_ready_reg <= 1'b1;                       // R6
            else if (state_reg == CRS_XFER &&
                     idx_reg == 6'(IMG_WORDS - 1))
                image_ready_reg <= 1'b0;
            if (xfer_cmd_i)
                xfer_req_reg <= 1'b1;
            else if (state_reg == CRS_XFER)
                xfer_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ms_wr_o   <= 1'b0;
            ms_addr_o <= '0;
            ms_data_o <= '0;
        end else begin
            ms_wr_o   <= state_reg == CRS_XFER;                // R13
            ms_addr_o <= ms_addr(cur_s, cur_b, cur_p);         // R10
            ms_data_o <= buf_mem[buf_addr(cur_s, cur_b, cur_p)];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            terr_meta_reg <= 1'b0;
            terr_reg      <= 1'b0;
        end else begin
            terr_meta_reg <= lerr_reg;
            terr_reg      <= terr_meta_reg;
        end
    end

    assign timing_err_o  = terr_reg;
    assign image_ready_o = image_ready_reg;
    assign xfer_busy_o   = state_reg == CRS_XFER;
endmodule : crs_reader_sync

/* bench/crs_reader_model.sv */
`timescale 1ns/10ps

module crs_reader_model (
    // Link clock and reader controls
    input  wire logic        link_clk_i,
    input  wire logic        pick_i,
    input  wire logic        probe_i,
    // Sensing lines
    output logic             slot_o,
    output logic             card_present_o = 1'b0,
    output logic [89:0]      brush1_o,
    output logic [89:0]      brush2_o
);
    logic [7:0] pos_reg   = 8'h00;
    logic       armed_reg = 1'b0;
    logic       pick_d_reg = 1'b0;
    logic [3:0] row;
    logic       h1;
    logic       h2;
    assign row = pos_reg[7:4];
    assign h1  = (row == 4'h0) || (row == 4'h5) || (row == 4'h9);
    assign h2  = (row == 4'h1) || (row == 4'h7);
    // Twelve slots 16 cycles apart, then a 64 cycle gap
    assign slot_o = (pos_reg < 8'hc0) && (pos_reg[3:0] < 4'h2);
    // Brushes float to the inverse outside a probe, so stale reads show
    assign brush1_o = {90{h1 ^ !probe_i}};
    assign brush2_o = {90{h2 ^ !probe_i}};
    always_ff @(posedge link_clk_i) begin
        pos_reg <= (pos_reg == 8'hef) ? 8'h00 : pos_reg + 8'h01;
    end
    // Arm on the pick edge so a long pick never feeds a second card
    always_ff @(posedge link_clk_i) begin
        pick_d_reg <= pick_i;
        if (pick_i && !pick_d_reg)
            armed_reg <= 1'b1;
        else if (pos_reg == 8'he8)
            armed_reg <= 1'b0;
    end
    always_ff @(posedge link_clk_i) begin
        if (pos_reg == 8'he8)
            card_present_o <= armed_reg;
        else if (pos_reg == 8'hc8)
            card_present_o <= 1'b0;
    end
endmodule : crs_reader_model

/* bench/crs_reader_sync_assertions.sv */
`timescale 1ns/10ps

module crs_chk (
    // Clocks and reset
    input wire logic       sys_clk_i,
    input wire logic       link_clk_i,
    input wire logic       rst_i,
    // Watched ports
    input wire logic       card_present_i,
    input wire logic       probe_o,
    input wire logic       pick_o,
    input wire logic [1:0] stacker_o,
    input wire logic       ms_wr_o,
    input wire logic [7:0] ms_addr_o,
    input wire logic       xfer_busy_o,
    input wire logic       image_ready_o
);
    logic [5:0] pick_reg;
    logic [5:0] wr_reg;
    always_ff @(posedge link_clk_i) begin
        pick_reg <= pick_o ? pick_reg + 6'h01 : 6'h00;
    end
    always_ff @(posedge sys_clk_i) begin
        wr_reg <= ms_wr_o ? wr_reg + 6'h01 : 6'h00;
    end
    sequence s_probe;
        probe_o [*8] ##1 !probe_o;
    endsequence
    sequence s_first;
        ms_wr_o && (ms_addr_o == 8'h01);
    endsequence
    property p_probe_len; @(posedge link_clk_i) disable iff (rst_i)
        $rose(probe_o) |-> s_probe; endproperty
    a_probe_len: assert property (p_probe_len) else $error("probe");
    property p_probe_card; @(posedge link_clk_i) disable iff (rst_i)
        $rose(probe_o) |-> $past(card_present_i, 3); endproperty
    a_probe_card: assert property (p_probe_card) else $error("card");
    property p_pick_len; @(posedge link_clk_i) disable iff (rst_i)
        $fell(pick_o) |-> pick_reg == 6'h14; endproperty
    a_pick_len: assert property (p_pick_len) else $error("pick");
    property p_stk; @(posedge link_clk_i) disable iff (rst_i)
        $changed(stacker_o) |-> $rose(pick_o); endproperty
    a_stk: assert property (p_stk) else $error("stacker");
    property p_burst; @(posedge sys_clk_i) disable iff (rst_i)
        $fell(ms_wr_o) |-> wr_reg == 6'h28; endproperty
    a_burst: assert property (p_burst) else $error("burst");
    property p_first; @(posedge sys_clk_i) disable iff (rst_i)
        $rose(xfer_busy_o) |=> s_first; endproperty
    a_first: assert property (p_first) else $error("first word");
    property p_hold; @(posedge sys_clk_i) disable iff (rst_i)
        image_ready_o && !xfer_busy_o |=> image_ready_o; endproperty
    a_hold: assert property (p_hold) else $error("image lost");
    property p_wr_busy; @(posedge sys_clk_i) disable iff (rst_i)
        ms_wr_o |-> $past(xfer_busy_o); endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("stray write");
endmodule : crs_chk

bind crs_reader_sync crs_chk u_chk (.sys_clk_i, .link_clk_i, .rst_i,
    .card_present_i, .probe_o, .pick_o, .stacker_o, .ms_wr_o, .ms_addr_o,
    .xfer_busy_o, .image_ready_o);

/* bench/tb.sv */
`timescale 1ns/10ps

module tb;
    import crs_pkg::*;
    logic sys_clk_i = 1'b0, link_clk_i = 1'b0, rst_i = 1'b1;
    logic feed_cmd_i = 1'b0, xfer_cmd_i = 1'b0;
    logic [1:0] stacker_i = 2'h0, stacker_o;
    logic image_ready_o, xfer_busy_o, timing_err_o, ms_wr_o;
    logic probe_o, pick_o, slot_i, card_present_i;
    logic [7:0] ms_addr_o;
    logic [WORD_W-1:0] ms_data_o;
    logic [COLS-1:0] brush1_i, brush2_i;
    int err_total = 0, cmp_count = 0, probes = 0, picks = 0, cyc = 0;
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    initial begin
        #7;
        forever #16 link_clk_i = ~link_clk_i;
    end
    crs_reader_sync DUT (.sys_clk_i, .rst_i, .feed_cmd_i, .stacker_i,
        .xfer_cmd_i, .image_ready_o, .xfer_busy_o, .timing_err_o, .ms_wr_o,
        .ms_addr_o, .ms_data_o, .link_clk_i, .slot_i, .card_present_i,
        .brush1_i, .brush2_i, .probe_o, .pick_o, .stacker_o);
    crs_reader_model FAR (.link_clk_i, .pick_i(pick_o), .probe_i(probe_o),
        .slot_o(slot_i), .card_present_o(card_present_i),
        .brush1_o(brush1_i), .brush2_o(brush2_i));
    always @(posedge probe_o) probes++;
    always @(posedge pick_o) picks++;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] exp, got);
        cmp_count++;
        if (exp !== got) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] exp_addr(input int k);
        int b;
        int g;
        b = (k % 20) / 2;
        g = (b % 5) * 2 + k / 20;
        return 8'(g * 10 + 5 * (k % 2) + ((b < 5) ? 1 : 102));
    endfunction : exp_addr
    function automatic logic [19:0] exp_data(input int k);
        logic [3:0] d;
        d = (k < 20) ? ((k % 2) ? 4'h2 : 4'h9) : ((k % 2) ? 4'h1 : 4'h2);
        return {5{d}};
    endfunction : exp_data
    task automatic t_idle;
        repeat (3200) @(negedge sys_clk_i);
        chk("picks", 0, picks);
        chk("probes", 0, probes);
        chk("ready", 0, {31'h0, image_ready_o});
    endtask : t_idle
    task automatic t_card(input logic [1:0] st, input int nr);
        int p0;
        int n;
        p0 = probes;
        stacker_i = st;
        feed_cmd_i = 1'b1;
        @(negedge sys_clk_i);
        feed_cmd_i = 1'b0;
        n = 0;
        while (image_ready_o !== 1'b1 && n < 4000) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("picks", nr, picks);
        chk("stacker", st, stacker_o);
        chk("probes", 12, probes - p0);
        chk("timing", 0, {31'h0, timing_err_o});
        repeat (50) @(negedge sys_clk_i);
        chk("ready", 1, {31'h0, image_ready_o});
        xfer_cmd_i = 1'b1;
        @(negedge sys_clk_i);
        xfer_cmd_i = 1'b0;
        n = 0;
        repeat (60) begin
            @(negedge sys_clk_i);
            if (ms_wr_o === 1'b1) begin
                chk("addr", exp_addr(n), ms_addr_o);
                chk("data", exp_data(n), ms_data_o[19:0]);
                chk("data_hi", ((n % 20) / 2 % 5 == 4) ? 0 : exp_data(n),
                    ms_data_o[39:20]);
                n++;
            end
        end
        chk("words", 40, n);
        chk("cleared", 0, {31'h0, image_ready_o});
    endtask : t_card
    initial begin
        repeat (28) @(negedge sys_clk_i);
        rst_i = 1'b0;
        t_idle();
        for (int s = 0; s < 3; s++)
            t_card(2'(s), s + 1);
        stop_test();
    end
endmodule : tb
